/* core/ssd_map.svh */
// Register map, field positions, reset values and divider counts of the serial port
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SSD_IDX_DATA 8'h21
`define SSD_IDX_CTRL 8'h22
`define SSD_IDX_CSR 8'h23
`define SSD_IDX_EVT 8'h24
`define SSD_IDX_MASK 8'h25

// ----------------------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------------------
`define SSD_CSR_DONE 7
`define SSD_CSR_WCOL 6
`define SSD_CSR_OVR 5
`define SSD_CSR_MFAULT 4
`define SSD_CSR_RSVD 3
`define SSD_CSR_OUTDIS 2
`define SSD_CSR_SELSOFT 1
`define SSD_CSR_SOFTLVL 0

// ----------------------------------------------------------------------------
// Event status / mask bit positions
// ----------------------------------------------------------------------------
`define SSD_EVT_DONE 0
`define SSD_EVT_MFAULT 1
`define SSD_EVT_OVR 2
`define SSD_EVT_WCOL 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSD_CTRL_RST 8'h00
`define SSD_CSR_RST 8'h00
`define SSD_EVT_RST 4'h0

// ----------------------------------------------------------------------------
// Half periods of the master serial clock, in clock cycles, and serial clock edges per byte
// ----------------------------------------------------------------------------
`define SSD_HALF_DIV4 7'h02
`define SSD_HALF_DIV8 7'h04
`define SSD_HALF_DIV16 7'h08
`define SSD_HALF_DIV32 7'h10
`define SSD_HALF_DIV64 7'h20
`define SSD_HALF_DIV128 7'h40
`define SSD_EDGES_PER_BYTE 5'h10

`endif

/* core/ssd_pkg.sv */
// Types shared by the serial port register block
package ssd_pkg;

   // Control register layout
   typedef struct packed {
      logic irq_en;
      logic port_en;
      logic div_en;
      logic master_select;
      logic cpol;
      logic cpha;
      logic [1:0] rate;
   } ssd_ctrl_t;

   // Serial pins seen from outside
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic ss_n;
   } ssd_pad_in_t;

   // Serial pins driven by the block
   typedef struct packed {
      logic sclk;
      logic sclk_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
   } ssd_pad_out_t;

   // Master clock generator state
   typedef enum logic [0:0] {SSD_IDLE, SSD_RUN} ssd_state_t;

endpackage

/* core/ssd_spi_regs.sv */
// Byte-wide serial peripheral: status, select control, data buffer, APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "ssd_map.svh"
// ----------------------------------------------------------------------------
// Operation
// RQ1: master mode sees select low, set fault flag
// RQ2: fault flag with irq enable raises interrupt
// RQ3: fault clears after control access then write
// RQ4: reserved status bit written zero, reads zero
// RQ5: output disable releases serial data output
// RQ6: data output driven only with port enabled
// RQ7: soft select source ignores pin, frees it
// RQ8: soft level zero selects, one deselects
// RQ9: master data write starts a byte
// RQ10: completion copies shift register to buffer
// RQ11: data read returns buffer, not shifter
// RQ12: writes ignored while done flag uncleared
// RQ13: data write loads shift register directly
// RQ14: data, control, status at indices 21h-23h
// RQ15: data register has no defined reset
// RQ16: fault clears port enable and master select
// RQ17: one irq from done, fault, overrun flags
// RQ18: fault uses effective internal select
// ----------------------------------------------------------------------------
module ssd_spi_regs #(
   parameter int ADDR_W = 12
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Serial pins
   input wire ssd_pkg::ssd_pad_in_t i_pad,
   output ssd_pkg::ssd_pad_out_t o_pad,
   output logic o_ss_pin_free,
   // Interrupt
   output logic o_irq
);
   import ssd_pkg::*;

   // ----------------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------------
   generate
      if (ADDR_W < 10) begin : g_bad_addr
         $error("ADDR_W must be at least 10");
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   ssd_ctrl_t ctrl;
   ssd_state_t state;
   logic out_dis, sel_soft, soft_level;
   logic done_flag, wcol, ovr, mfault;
   logic done_armed, mfault_armed;
   logic [3:0] evt_stat, evt_mask;
   logic [7:0] shifter, rx_hold, rx_buf, next_rdata;
   logic in_bit, sclk_lvl, sclk_d3;
   logic [3:0] bit_cnt;
   logic [4:0] edge_cnt;
   logic [6:0] div_cnt, half_div;
   logic [3:0] sync1, sync2;
   ssd_pad_in_t pin;
   logic [7:0] idx;
   logic aligned, hit_data, hit_ctrl, hit_csr, hit_evt, hit_mask, mapped;
   logic apb_done, wr, rd, acc_ctrl, acc_csr, acc_data;
   logic sel_n, mf_evt, busy, dr_write, dr_ok, start;
   logic tick, edge_ev, lead, sample_ev, shift_ev, din, last_sample, xfer_end;
   logic [7:0] rx_byte;

   // ----------------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------------
   // Two flops per pin before any logic looks at it
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               sync1[gi] <= 1'b1;
               sync2[gi] <= 1'b1;
            end else if (i_ce) begin
               sync1[gi] <= i_pad[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate
   assign pin = sync2;

   // Delayed serial clock for edge finding
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sclk_d3 <= 1'b0;
      end else if (i_ce) begin
         sclk_d3 <= pin.sclk;
      end
   end

   // ----------------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------------
   assign idx = i_paddr[9:2];
   assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr >> 10) == '0;
   // Register indices
   assign hit_data = aligned && idx == `SSD_IDX_DATA; // RQ14
   assign hit_ctrl = aligned && idx == `SSD_IDX_CTRL; // RQ14
   assign hit_csr = aligned && idx == `SSD_IDX_CSR; // RQ14
   assign hit_evt = aligned && idx == `SSD_IDX_EVT;
   assign hit_mask = aligned && idx == `SSD_IDX_MASK;
   assign mapped = hit_data | hit_ctrl | hit_csr | hit_evt | hit_mask;

   // Zero wait states; the access phase completes at once
   assign o_pready = i_psel & i_penable & i_ce;
   assign apb_done = o_pready;
   assign o_pslverr = apb_done & ~mapped;
   assign wr = apb_done & i_pwrite & i_pstrb[0] & mapped;
   assign rd = apb_done & ~i_pwrite & mapped;
   assign acc_ctrl = apb_done & hit_ctrl;
   assign acc_csr = apb_done & hit_csr;
   assign acc_data = apb_done & hit_data;

   // Read mux
   always_comb begin
      next_rdata = 8'h00;
      if (hit_data) begin
         next_rdata = rx_buf; // RQ11
      end else if (hit_ctrl) begin
         next_rdata = ctrl;
      end else if (hit_csr) begin
         next_rdata = {done_flag, wcol, ovr, mfault, 1'b0, out_dis, sel_soft, soft_level}; // RQ4
      end else if (hit_evt) begin
         next_rdata = {4'h0, evt_stat};
      end else if (hit_mask) begin
         next_rdata = {4'h0, evt_mask};
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_prdata <= 32'h00000000;
      end else if (i_ce && i_psel && !i_penable) begin
         o_prdata <= {24'h000000, next_rdata};
      end
   end

   // ----------------------------------------------------------------------------
   // Select and mode fault
   // ----------------------------------------------------------------------------
   assign sel_n = sel_soft ? soft_level : pin.ss_n; // RQ7 RQ8
   assign mf_evt = ctrl.master_select & ~sel_n; // RQ1 RQ18
   assign o_ss_pin_free = sel_soft | ~ctrl.port_en; // RQ7

   // Data register write acceptance
   assign busy = (state == SSD_RUN) | (bit_cnt != 4'h0);
   assign dr_write = wr & hit_data;
   assign dr_ok = dr_write & ~(done_flag & ~done_armed) & ~busy; // RQ12
   assign start = dr_ok & ctrl.master_select & ctrl.port_en & ~mf_evt; // RQ9

   // Control register; hardware clears port enable and master select on fault
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl <= `SSD_CTRL_RST;
      end else if (i_ce) begin
         if (wr && hit_ctrl) begin
            ctrl <= i_pwdata[7:0];
         end
         if (mf_evt) begin
            ctrl.port_en <= 1'b0; // RQ16
            ctrl.master_select <= 1'b0; // RQ16
         end
      end
   end

   // Software-owned status bits
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         out_dis <= 1'b0;
         sel_soft <= 1'b0;
         soft_level <= 1'b0;
      end else if (i_ce && wr && hit_csr) begin
         out_dis <= i_pwdata[`SSD_CSR_OUTDIS];
         sel_soft <= i_pwdata[`SSD_CSR_SELSOFT];
         soft_level <= i_pwdata[`SSD_CSR_SOFTLVL];
      end
   end

   // Mode fault flag with two-step clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mfault <= 1'b0;
         mfault_armed <= 1'b0;
      end else if (i_ce) begin
         if (mf_evt) begin
            mfault <= 1'b1; // RQ1
            mfault_armed <= 1'b0;
         end else if (wr && hit_ctrl && mfault_armed) begin
            mfault <= 1'b0; // RQ3
            mfault_armed <= 1'b0;
         end else if (acc_ctrl && mfault) begin
            mfault_armed <= 1'b1; // RQ3
         end
      end
   end

   // Done flag: status read then data access clears it
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         done_flag <= 1'b0;
         done_armed <= 1'b0;
      end else if (i_ce) begin
         if (xfer_end) begin
            done_flag <= 1'b1;
            done_armed <= 1'b0;
         end else if (acc_data && done_armed) begin
            done_flag <= 1'b0;
            done_armed <= 1'b0;
         end else if (rd && hit_csr && done_flag) begin
            done_armed <= 1'b1; // RQ12
         end
      end
   end

   // Overrun and write collision flags; set wins over clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ovr <= 1'b0;
         wcol <= 1'b0;
      end else if (i_ce) begin
         if (xfer_end && done_flag) begin
            ovr <= 1'b1;
         end else if (rd && hit_csr) begin
            ovr <= 1'b0;
         end
         if (dr_write && busy) begin
            wcol <= 1'b1;
         end else if (acc_data && done_armed) begin
            wcol <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Serial clock and edges
   // ----------------------------------------------------------------------------
   // Half period from rate select
   always_comb begin
      case ({ctrl.div_en, ctrl.rate})
         3'h4: half_div = `SSD_HALF_DIV4;
         3'h0: half_div = `SSD_HALF_DIV8;
         3'h1: half_div = `SSD_HALF_DIV16;
         3'h6: half_div = `SSD_HALF_DIV32;
         3'h2: half_div = `SSD_HALF_DIV64;
         3'h3: half_div = `SSD_HALF_DIV128;
         default: half_div = `SSD_HALF_DIV8;
      endcase
   end

   assign tick = (state == SSD_RUN) && (div_cnt == half_div - 7'h01);
   assign edge_ev = ctrl.master_select ? tick :
                    (ctrl.port_en & ~sel_n & (pin.sclk != sclk_d3));
   assign lead = ctrl.master_select ? (sclk_lvl == ctrl.cpol) : (pin.sclk != ctrl.cpol);
   assign sample_ev = edge_ev & (lead ^ ctrl.cpha);
   assign shift_ev = edge_ev & ~(lead ^ ctrl.cpha);
   assign din = ctrl.master_select ? pin.miso : pin.mosi;
   assign last_sample = sample_ev && bit_cnt == 4'h7;
   assign xfer_end = ctrl.master_select ? (tick && edge_cnt == `SSD_EDGES_PER_BYTE - 5'h01)
                                        : last_sample;
   assign rx_byte = last_sample ? {shifter[6:0], din} : rx_hold;

   // Master clock generator
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= SSD_IDLE;
         div_cnt <= 7'h00;
         edge_cnt <= 5'h00;
         sclk_lvl <= 1'b0;
      end else if (i_ce) begin
         case (state)
            SSD_IDLE: begin
               sclk_lvl <= ctrl.cpol;
               div_cnt <= 7'h00;
               edge_cnt <= 5'h00;
               if (start) begin
                  state <= SSD_RUN; // RQ9
               end
            end
            SSD_RUN: begin
               if (mf_evt || !ctrl.master_select) begin
                  state <= SSD_IDLE;
               end else if (tick) begin
                  div_cnt <= 7'h00;
                  sclk_lvl <= ~sclk_lvl;
                  edge_cnt <= edge_cnt + 5'h01;
                  if (xfer_end) begin
                     state <= SSD_IDLE;
                  end
               end else begin
                  div_cnt <= div_cnt + 7'h01;
               end
            end
            default: state <= SSD_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Shift register and receive buffer
   // ----------------------------------------------------------------------------
   // Shifter, sampled bit and bit count
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shifter <= 8'h00;
         in_bit <= 1'b0;
         bit_cnt <= 4'h0;
         rx_hold <= 8'h00;
      end else if (i_ce) begin
         if (dr_ok) begin
            shifter <= i_pwdata[7:0]; // RQ13
         end else if (!ctrl.master_select && (sel_n || !ctrl.port_en)) begin
            bit_cnt <= 4'h0;
         end else if (ctrl.master_select && state == SSD_IDLE) begin
            bit_cnt <= 4'h0;
         end else if (sample_ev) begin
            in_bit <= din;
            if (last_sample) begin
               rx_hold <= {shifter[6:0], din};
               bit_cnt <= 4'h0;
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
            end
         end else if (shift_ev && bit_cnt != 4'h0) begin
            shifter <= {shifter[6:0], in_bit};
         end
      end
   end

   // Receive buffer, no reset value
   always_ff @(posedge i_clk) begin
      if (i_ce && xfer_end && !done_flag) begin
         rx_buf <= rx_byte; // RQ10 RQ15
      end
   end

   // ----------------------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------------------
   always_comb begin
      o_pad.sclk = sclk_lvl;
      o_pad.sclk_oe = ctrl.port_en & ctrl.master_select;
      o_pad.mosi = shifter[7];
      o_pad.mosi_oe = ctrl.port_en & ctrl.master_select & ~out_dis; // RQ5 RQ6
      o_pad.miso = shifter[7];
      o_pad.miso_oe = ctrl.port_en & ~ctrl.master_select & ~out_dis & ~sel_n; // RQ5 RQ6
   end

   // ----------------------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------------------
   // Sticky events, write one to clear, set wins
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         evt_stat <= `SSD_EVT_RST;
         evt_mask <= `SSD_EVT_RST;
      end else if (i_ce) begin
         evt_stat <= (evt_stat & ~((wr && hit_evt) ? i_pwdata[3:0] : 4'h0))
                     | {dr_write & busy, xfer_end & done_flag, mf_evt, xfer_end};
         if (wr && hit_mask) begin
            evt_mask <= i_pwdata[3:0];
         end
      end
   end

   // Single level interrupt
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= (ctrl.irq_en & (done_flag | mfault | ovr)) // RQ2 RQ17
                  | (|(evt_stat & evt_mask));
      end
   end

endmodule

/* testbench/ssd_spi_regs_assertions.sv */
// Port-level checker of the serial port register block
`timescale 1ns/1ns
module ssd_spi_regs_checker #(
   parameter int ADDR_W = 12
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // APB
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Pins and interrupt
   input wire ssd_pkg::ssd_pad_in_t i_pad,
   input wire ssd_pkg::ssd_pad_out_t o_pad,
   input wire logic o_ss_pin_free,
   input wire logic o_irq
);
   import ssd_pkg::*;
   logic acc;
   logic wr;
   logic mapped;
   logic [2:0] csr_sh;
   logic irq_en_sh;
   logic [3:0] mask_sh;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Taken transfers
   assign acc = i_psel && i_penable && i_ce;
   assign wr = acc && i_pwrite && i_pstrb[0];
   assign mapped = i_paddr inside {12'h084, 12'h088, 12'h08C, 12'h090, 12'h094};
   // Shadow of software-written bits
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         csr_sh <= 3'h0;
         irq_en_sh <= 1'b0;
         mask_sh <= 4'h0;
      end else if (wr) begin
         if (i_paddr == 12'h08C) begin
            csr_sh <= i_pwdata[2:0];
         end
         if (i_paddr == 12'h088) begin
            irq_en_sh <= i_pwdata[7];
         end
         if (i_paddr == 12'h094) begin
            mask_sh <= i_pwdata[3:0];
         end
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   map_decode_a: assert property (acc && mapped |-> !o_pslverr)
      else $error("mapped access refused");
   unmapped_err_a: assert property (acc && !mapped |-> o_pslverr)
      else $error("unmapped access accepted");
   reserved_zero_a: assert property (acc && !i_pwrite && i_paddr == 12'h08C |-> !o_prdata[3])
      else $error("reserved status bit reads one");
   outdis_release_a: assert property (csr_sh[2] |-> !o_pad.mosi_oe && !o_pad.miso_oe)
      else $error("data output driven while disabled");
   soft_pin_free_a: assert property (csr_sh[1] |-> o_ss_pin_free)
      else $error("select pin held under soft select");
   soft_deselect_a: assert property (csr_sh[1] && csr_sh[0] |-> !o_pad.miso_oe)
      else $error("slave output driven while deselected");
   soft_fault_a: assert property (csr_sh[1] && !csr_sh[0] |-> ##[0:4] !o_pad.sclk_oe)
      else $error("soft select low left master active");
   pin_fault_a: assert property ($fell(i_pad.ss_n) && !csr_sh[1] |-> ##[1:6] !o_pad.sclk_oe)
      else $error("select pin low left master active");
   irq_quiet_a: assert property ((!irq_en_sh && mask_sh == 4'h0) [*3] |-> !o_irq)
      else $error("interrupt raised while disabled");
   // Main scenarios reached
   cover property ($rose(o_irq));
   cover property (acc && o_pslverr);
   cover property ($rose(o_pad.sclk) && o_pad.sclk_oe);
endmodule
bind ssd_spi_regs ssd_spi_regs_checker #(.ADDR_W(ADDR_W)) i_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pad(i_pad),
   .o_pad(o_pad), .o_ss_pin_free(o_ss_pin_free), .o_irq(o_irq)
);

/* testbench/ssd_peer.sv */
// Behavioural serial peer facing the block's pins
`timescale 1ns/1ns
module ssd_peer (
   // Pins from the block
   input wire logic i_sclk,
   input wire logic i_dout,
   input wire logic i_dout_oe,
   input wire logic i_ss_n,
   // Pins toward the block
   output ssd_pkg::ssd_pad_in_t o_pad
);
   import ssd_pkg::*;
   logic [7:0] sh = 8'h00;
   logic [7:0] rx = 8'h00;
   logic ext_clk = 1'b0;
   logic ext_sel_n = 1'b1;
   logic edge_clk;
   // Pin levels; released data shows the inverse of its last bit
   assign edge_clk = i_sclk ^ ext_clk;
   assign o_pad.sclk = ext_clk;
   assign o_pad.mosi = ext_sel_n ? ~sh[7] : sh[7];
   assign o_pad.miso = sh[7];
   assign o_pad.ss_n = ext_sel_n & i_ss_n; // Pulled up when unselected
   // Capture on rising, shift on falling serial clock
   always @(posedge edge_clk) rx <= {rx[6:0], i_dout_oe ? i_dout : ~rx[0]};
   always @(negedge edge_clk) sh <= {sh[6:0], ~sh[7]};
   // One frame as master; clock stands low outside it
   task automatic master_byte(input logic [7:0] d);
      sh = d;
      ext_sel_n = 1'b0;
      #200;
      repeat (8) begin
         ext_clk = 1'b1;
         #200;
         ext_clk = 1'b0;
         #200;
      end
      ext_sel_n = 1'b1;
   endtask
endmodule

/* testbench/ssd_spi_regs_test.sv */
// Self-checking bench of the serial port register block
`timescale 1ns/1ns
`include "ssd_map.svh"
module ssd_spi_regs_test;
   import ssd_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ss_n = 1'b1;
   ssd_pad_in_t pad_in;
   ssd_pad_out_t pad_out;
   logic pin_free;
   logic irq;
   logic [31:0] rd;
   logic err;
   logic [7:0] b;
   logic [7:0] t;
   int seed = 57;
   int n_mismatch = 0;
   int num_checks = 0;
   int k;
   int cnt;
   always #25 clk = ~clk;
   ssd_spi_regs i_dut (
      .i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'h1),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pad(pad_in),
      .o_pad(pad_out), .o_ss_pin_free(pin_free), .o_irq(irq)
   );
   ssd_peer i_peer (
      .i_sclk(pad_out.sclk & pad_out.sclk_oe),
      .i_dout(pad_out.mosi_oe ? pad_out.mosi : pad_out.miso),
      .i_dout_oe(pad_out.mosi_oe | pad_out.miso_oe),
      .i_ss_n(ss_n),
      .o_pad(pad_in)
   );
   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_pin(input string s, input logic e, input logic g);
      chk(s, {7'h0, e}, {7'h0, g});
   endtask
   // Output drive expected from control and status bytes
   function automatic logic out_on(input logic [7:0] c, input logic [7:0] s);
      return c[6] & ~s[2];
   endfunction
   // Control byte after hardware fault clearing
   function automatic logic [7:0] fault_ctrl(input logic [7:0] c);
      return c & 8'hAF;
   endfunction
   task automatic apb(input logic w, input logic [7:0] x, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, x, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] x, input logic [7:0] d);
      apb(1'b1, x, d);
      @(posedge clk);
   endtask
   task automatic rchk(input string s, input logic [7:0] x, input logic [7:0] e,
                       input logic [7:0] m);
      apb(1'b0, x, 8'h00);
      chk(s, e, rd[7:0] & m);
   endtask
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk_pin("irq", v, irq);
      if (irq !== v) begin
         complete_run();
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rchk("ctrl rst", `SSD_IDX_CTRL, `SSD_CTRL_RST, 8'hF0);
      rchk("csr rst", `SSD_IDX_CSR, `SSD_CSR_RST, 8'hFF);
      apb(1'b0, 8'h26, 8'h00);
      chk_pin("unmapped", 1'b1, err);
      $display("test reset finished");
      // Master transfers with a write while done is pending
      wr(`SSD_IDX_CTRL, 8'hD1);
      for (k = 0; k < 3; k++) begin
         b = $random(seed);
         t = $random(seed);
         i_peer.sh = t;
         wr(`SSD_IDX_DATA, b);
         wait_irq(1'b1);
         wr(`SSD_IDX_DATA, 8'h5A);
         cnt = 0;
         repeat (40) begin
            @(posedge clk);
            cnt += pad_out.sclk;
         end
         chk("sclk idle", 8'h00, cnt[7:0]);
         chk("peer rx", b, i_peer.rx);
         rchk("csr done", `SSD_IDX_CSR, 8'h80, 8'h9F);
         rchk("rx buf", `SSD_IDX_DATA, t, 8'hFF);
         wait_irq(1'b0);
      end
      chk_pin("mosi on", out_on(8'hD1, 8'h00), pad_out.mosi_oe);
      wr(`SSD_IDX_CSR, 8'h04);
      chk_pin("mosi off", out_on(8'hD1, 8'h04), pad_out.mosi_oe);
      wr(`SSD_IDX_CSR, 8'h00);
      $display("test master finished");
      // Fault from the select pin, cleared by access then write
      ss_n <= 1'b0;
      wait_irq(1'b1);
      chk_pin("fault oe", 1'b0, pad_out.sclk_oe);
      rchk("fault", `SSD_IDX_CSR, 8'h10, 8'h9F);
      ss_n <= 1'b1;
      wr(`SSD_IDX_CTRL, 8'h51);
      rchk("fault kept", `SSD_IDX_CSR, 8'h10, 8'h9F);
      rchk("ctrl", `SSD_IDX_CTRL, 8'h51, 8'hFF);
      wr(`SSD_IDX_CTRL, 8'h51);
      rchk("fault clr", `SSD_IDX_CSR, 8'h00, 8'h9F);
      // Soft select low faults, pin ignored when soft
      wr(`SSD_IDX_CSR, 8'h02);
      chk_pin("pin free", 1'b1, pin_free);
      rchk("soft fault", `SSD_IDX_CSR, 8'h12, 8'h9F);
      rchk("ctrl flt", `SSD_IDX_CTRL, fault_ctrl(8'h51), 8'hFF);
      wr(`SSD_IDX_CSR, 8'h03);
      wr(`SSD_IDX_CTRL, 8'h51);
      ss_n <= 1'b0;
      repeat (10) @(posedge clk);
      rchk("pin ignored", `SSD_IDX_CSR, 8'h03, 8'h9F);
      chk_pin("master on", 1'b1, pad_out.sclk_oe);
      ss_n <= 1'b1;
      $display("test fault finished");
      // Slave frame on the 400 ns link clock
      wr(`SSD_IDX_CTRL, 8'hC0);
      chk_pin("deselected", 1'b0, pad_out.miso_oe);
      wr(`SSD_IDX_CSR, 8'h02);
      chk_pin("selected", out_on(8'hC0, 8'h02), pad_out.miso_oe);
      wr(`SSD_IDX_CSR, 8'h00);
      b = $random(seed);
      wr(`SSD_IDX_DATA, b);
      rchk("not shifter", `SSD_IDX_DATA, t, 8'hFF);
      t = $random(seed);
      i_peer.master_byte(t);
      wait_irq(1'b1);
      chk("peer got", b, i_peer.rx);
      rchk("slv done", `SSD_IDX_CSR, 8'h80, 8'h9F);
      rchk("slv rx", `SSD_IDX_DATA, t, 8'hFF);
      wait_irq(1'b0);
      $display("test slave finished");
      // Sticky events behind the mask
      wr(`SSD_IDX_CTRL, 8'h40);
      wr(`SSD_IDX_MASK, 8'h01);
      wait_irq(1'b1);
      rchk("events", `SSD_IDX_EVT, 8'h03, 8'h03);
      wr(`SSD_IDX_EVT, 8'h03);
      rchk("evt clr", `SSD_IDX_EVT, 8'h00, 8'h03);
      wait_irq(1'b0);
      wr(`SSD_IDX_MASK, 8'h00);
      $display("test events finished");
      complete_run();
   end
endmodule
